/* File: dv/flfc_ctrl_bench.sv */
// self-checking bench for the fastlock control block
`timescale 1ns/1ps
module flfc_ctrl_bench;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [23:0] wdata = 24'h000000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [23:0] rdata;
    logic        pd_event_pin;
    logic        fl_pin_in;
    logic        fl_pin_out;
    logic        fl_pin_oe_n;
    logic        fastlock_active;
    logic        wide_frac;
    logic [21:0] main_fraction_denominator;
    logic [4:0]  pump_mult;
    logic        slip_sample_en;
    logic        ld_sample_en;
    logic        main_counter_reset;
    logic        aux_counter_reset;
    logic        main_pump_tri;
    logic        aux_pump_tri;
    int          err_count = 0;
    int          n_checks = 0;
    int          n_slip = 0;
    int          n_ld = 0;
    wire [7:0]   pin_v = {fl_pin_oe_n, fl_pin_out, fastlock_active, pump_mult};
    wire [3:0]   rst_v = {main_counter_reset, aux_counter_reset,
                          main_pump_tri, aux_pump_tri};
    wire [23:0]  den_v = {1'b0, wide_frac, main_fraction_denominator};
    logic [23:0] den_in [4] = '{24'h3fffff, 24'h001000, 24'h7fffff, 24'h401000};
    logic [23:0] den_ex [4] = '{24'h000fff, 24'h000000, 24'h7fffff, 24'h401000};
    logic [7:0]  pin_ex [4] = '{8'h81, 8'h26, 8'h01, 8'h41};
    logic [3:0]  rst_ex [4] = '{4'h2, 4'h1, 4'ha, 4'h5};
    int          slip_ex [4] = '{16, 8, 4, 1};

    always #12.5 clk = ~clk;

    flfc_ctrl flfc_ctrl_i (
        .clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .pd_event_pin,
        .fl_pin_in, .fl_pin_out, .fl_pin_oe_n, .fastlock_active,
        .wide_frac, .main_fraction_denominator, .pump_mult,
        .slip_sample_en, .ld_sample_en, .main_counter_reset,
        .aux_counter_reset, .main_pump_tri, .aux_pump_tri
    );
    flfc_far_end flfc_far_end_i (
        .clk, .fl_pin_out, .fl_pin_oe_n, .pd_event_pin, .fl_pin_in
    );

    always @(posedge clk) begin
        if (slip_sample_en === 1'b1) n_slip++;
        if (ld_sample_en === 1'b1) n_ld++;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [23:0] m,
                          input logic [23:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata & m, exp);
    endtask
    // outputs land one edge after the write edge; two spare edges
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("unexpected at %0t: watchdog ran out", $time);
        finish_test();
    end

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        #1;
        check({16'h0, pin_v}, 24'h000081);
        check({20'h0, rst_v}, 24'h000000);
        check(den_v, 24'h000000);
        rd_chk(4'h1, 24'hffffff, 24'h000000);
        rd_chk(4'h2, 24'h000005, 24'h000000);
        wr_reg(4'h7, 24'h5a5a5a);
        rd_chk(4'h7, 24'hffffff, 24'h000000);
        $display("test reset_and_map done");
        for (int i = 0; i < 4; i++) begin
            wr_reg(4'h1, den_in[i]);
            settle();
            check(den_v, den_ex[i]);
            rd_chk(4'h1, 24'hffffff, den_in[i]);
        end
        $display("test denominator done");
        for (int i = 0; i < 4; i++) begin
            wr_reg(4'h0, {2'h0, 4'h5, 14'(i), 4'hd});
            settle();
            check({16'h0, pin_v}, {16'h0, pin_ex[i]});
        end
        // pin level needs about seven edges to come back through the far end
        settle();
        rd_chk(4'h2, 24'h000002, 24'h000002);
        $display("test pin_modes done");
        wr_reg(4'h0, {2'h0, 4'hf, 14'h0004, 4'hd});
        settle();
        check({16'h0, pin_v}, 24'h000001);
        wr_reg(4'h0, 24'h000000);
        settle();
        check({16'h0, pin_v}, 24'h000070);
        rd_chk(4'h2, 24'h7fff01, 24'h000801);
        flfc_far_end_i.send_events(7);
        settle();
        check({16'h0, pin_v}, 24'h000070);
        wr_reg(4'h0, 24'h000000);
        flfc_far_end_i.send_events(7);
        settle();
        check({16'h0, pin_v}, 24'h000070);
        flfc_far_end_i.send_events(1);
        settle();
        check({16'h0, pin_v}, 24'h000001);
        $display("test auto_fastlock done");
        // sixteen events per code keeps every divider back at phase zero
        for (int c = 0; c < 4; c++) begin
            wr_reg(4'h0, c[0] ? 24'h00280f : 24'h00080f);
            wr_reg(4'h0, {2'(c), 4'h0, 14'h0000, 4'hd});
            settle();
            n_slip = 0;
            n_ld = 0;
            flfc_far_end_i.send_events(16);
            settle();
            check(24'(n_slip), 24'(slip_ex[c]));
            check(24'(n_ld), c[0] ? 24'h000004 : 24'h000010);
        end
        $display("test dividers done");
        for (int i = 0; i < 4; i++) begin
            wr_reg(4'h0, 24'h00080f | (24'h000001 << (4 + i)));
            settle();
            check({20'h0, rst_v}, {20'h0, rst_ex[i]});
        end
        wr_reg(4'h0, 24'h0000ff);
        settle();
        check({20'h0, rst_v}, 24'h000005);
        rd_chk(4'h2, 24'h000004, 24'h000004);
        wr_reg(4'h2, 24'h000004);
        rd_chk(4'h2, 24'h000004, 24'h000000);
        wr_reg(4'h0, 24'h0000f5);
        settle();
        check({20'h0, rst_v}, 24'h000005);
        $display("test reset_word done");
        finish_test();
    end
endmodule

/* File: dv/flfc_ctrl_properties.sv */
// concurrent checks on the fastlock control ports
`timescale 1ns/1ps
module flfc_ctrl_properties (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        fl_pin_oe_n,
    input wire logic        fastlock_active,
    input wire logic        wide_frac,
    input wire logic [21:0] main_fraction_denominator,
    input wire logic [4:0]  pump_mult,
    input wire logic        slip_sample_en,
    input wire logic        ld_sample_en,
    input wire logic        main_counter_reset,
    input wire logic        aux_counter_reset,
    input wire logic        main_pump_tri,
    input wire logic        aux_pump_tri
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // events arrive at least four clocks apart, so pulses never merge
    sequence s_slip_quiet;
        !slip_sample_en [*3];
    endsequence
    sequence s_ld_quiet;
        !ld_sample_en [*3];
    endsequence
    a_pump_base_out: assert property (
        !fastlock_active |-> pump_mult == 5'h01)
        else $error("pump multiple not base outside fastlock");
    a_pump_mult_range: assert property (
        fastlock_active |-> pump_mult inside {[5'h01:5'h10]})
        else $error("pump multiple out of range");
    a_narrow_den_top: assert property (
        !wide_frac |-> main_fraction_denominator[21:12] == 10'h000)
        else $error("upper denominator bits used in narrow mode");
    a_main_reset_float: assert property (
        main_counter_reset |-> main_pump_tri)
        else $error("main pump not floated during counter reset");
    a_aux_reset_float: assert property (
        aux_counter_reset |-> aux_pump_tri)
        else $error("aux pump not floated during counter reset");
    a_fastlock_pin_driven: assert property (
        fastlock_active |-> !fl_pin_oe_n)
        else $error("fastlock pin released during fastlock");
    a_slip_pulse_gap: assert property (
        slip_sample_en |=> s_slip_quiet)
        else $error("slip sample pulse too long or too close");
    a_ld_pulse_gap: assert property (
        ld_sample_en |=> s_ld_quiet)
        else $error("lock detect sample pulse too long or too close");
endmodule

bind flfc_ctrl flfc_ctrl_properties flfc_ctrl_properties_i (
    .clk, .nrst, .fl_pin_oe_n, .fastlock_active, .wide_frac,
    .main_fraction_denominator, .pump_mult, .slip_sample_en,
    .ld_sample_en, .main_counter_reset, .aux_counter_reset,
    .main_pump_tri, .aux_pump_tri
);

/* File: dv/flfc_far_end.sv */
// far end: comparison event source and fastlock pin wire
`timescale 1ns/1ps
module flfc_far_end (
    input  wire logic clk,
    input  wire logic fl_pin_out,
    input  wire logic fl_pin_oe_n,
    output logic      pd_event_pin,
    output logic      fl_pin_in
);
    initial begin
        pd_event_pin = 1'b0;
        fl_pin_in = 1'b0;
    end
    // pin has no pull: a released pin toggles rather than holding a level
    always @(posedge clk) begin
        fl_pin_in <= fl_pin_oe_n ? ~fl_pin_in : fl_pin_out;
    end
    // three clocks high, four low: above the two-clock minimum each way
    task automatic send_events(input int n);
        repeat (n) begin
            @(posedge clk);
            pd_event_pin <= 1'b1;
            repeat (3) @(posedge clk);
            pd_event_pin <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
endmodule

/* File: hw/flfc_ctrl.sv */
// fastlock, slip reduction, denominator and counter reset control, top level
`timescale 1ns/1ps
`include "flfc_map.svh"
module flfc_ctrl (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  addr,
    input  wire logic [23:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [23:0] rdata,
    input  wire logic        pd_event_pin,
    input  wire logic        fl_pin_in,
    output logic             fl_pin_out,
    output logic             fl_pin_oe_n,
    output logic             fastlock_active,
    output logic             wide_frac,
    output logic      [21:0] main_fraction_denominator,
    output logic      [4:0]  pump_mult,
    output logic             slip_sample_en,
    output logic             ld_sample_en,
    output logic             main_counter_reset,
    output logic             aux_counter_reset,
    output logic             main_pump_tri,
    output logic             aux_pump_tri
);
    // programmed fields
    logic [13:0] main_fastlock_timeout_q;
    logic [3:0]  fastlock_pump_current_q;
    logic [1:0]  cycle_slip_reduction_q;
    logic        lock_detect_prescale_q;
    logic        aux_reset_q;
    logic        main_reset_q;
    logic        aux_pump_float_q;
    logic        main_pump_float_q;
    logic [21:0] den_raw_q;
    logic        wide_q;
    logic        bad_word_q;

    // fastlock timing
    flfc_pkg::flfc_fl_state_e fl_state_q;
    logic [14:0]              fl_cnt_q;
    flfc_pkg::flfc_mode_e     mode;
    logic                     fl_on;

    // decode
    logic        word_wr;
    logic [3:0]  word_sel;
    logic        fast_wr;
    logic        rst_wr;
    logic        freq_wr;
    logic        rst_fixed_ok;

    // comparison events and pin readback
    logic        pd_lvl;
    logic        pd_lvl_q;
    logic        pd_ev;
    logic        pin_in_lvl;
    logic [3:0]  slip_ratio_m1;
    logic [3:0]  ld_ratio_m1;
    logic [23:0] rd_val;

    assign word_wr      = wr && (addr == `FLFC_ADDR_WORD);
    assign word_sel     = wdata[3:0];
    assign fast_wr      = word_wr && (word_sel == `FLFC_SEL_FAST);
    assign rst_fixed_ok = (wdata & `FLFC_RST_FIXMASK) == `FLFC_RST_FIXVAL;
    assign rst_wr       = word_wr && (word_sel == `FLFC_SEL_RST)
                          && rst_fixed_ok;
    assign freq_wr      = word_wr && (word_sel == `FLFC_SEL_FREQ);

    flfc_sync3 u_pd_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (pd_event_pin),
        .dout (pd_lvl)
    );

    flfc_sync3 u_pin_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (fl_pin_in),
        .dout (pin_in_lvl)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pd_lvl_q <= 1'b0;
        end else begin
            pd_lvl_q <= pd_lvl;
        end
    end

    // one comparison event per rising edge of the settled level
    assign pd_ev = pd_lvl && !pd_lvl_q;

    // fastlock word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            main_fastlock_timeout_q <= `FLFC_TOC_RST;
            fastlock_pump_current_q <= `FLFC_CPF_RST;
            cycle_slip_reduction_q  <= `FLFC_SLIP_RST;
        end else if (fast_wr) begin
            main_fastlock_timeout_q <= wdata[`FLFC_TOC_MSB:`FLFC_TOC_LSB];
            fastlock_pump_current_q <= wdata[`FLFC_CPF_MSB:`FLFC_CPF_LSB];
            cycle_slip_reduction_q  <= wdata[`FLFC_SLIP_MSB:`FLFC_SLIP_LSB];
        end
    end

    // reset and float word, all bits default to normal operation
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lock_detect_prescale_q <= 1'b0;
            aux_reset_q            <= 1'b0;
            main_reset_q           <= 1'b0;
            aux_pump_float_q       <= 1'b0;
            main_pump_float_q      <= 1'b0;
        end else if (rst_wr) begin
            lock_detect_prescale_q <= wdata[`FLFC_LDPRE_BIT];
            aux_reset_q            <= wdata[`FLFC_AUXRST_BIT];
            main_reset_q           <= wdata[`FLFC_MAINRST_BIT];
            aux_pump_float_q       <= wdata[`FLFC_AUXFLT_BIT];
            main_pump_float_q      <= wdata[`FLFC_MAINFLT_BIT];
        end
    end

    // denominator configuration
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            den_raw_q <= `FLFC_DEN_RST;
            wide_q    <= 1'b0;
        end else if (wr && (addr == `FLFC_ADDR_DEN)) begin
            den_raw_q <= wdata[21:0];
            wide_q    <= wdata[`FLFC_DEN_WIDE_BIT];
        end
    end

    // malformed reset word is dropped and flagged; a new one beats the clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bad_word_q <= 1'b0;
        end else if (word_wr && (word_sel == `FLFC_SEL_RST)
                     && !rst_fixed_ok) begin
            bad_word_q <= 1'b1;
        end else if (wr && (addr == `FLFC_ADDR_STAT)
                     && wdata[`FLFC_STAT_ERR_BIT]) begin
            bad_word_q <= 1'b0;
        end
    end

    // pin function follows the timeout value
    always_comb begin
        if (main_fastlock_timeout_q >= `FLFC_TOC_AUTO_MIN) begin
            mode = flfc_pkg::FLFC_AUTO;
        end else begin
            unique case (main_fastlock_timeout_q[1:0])
                2'h0: mode = flfc_pkg::FLFC_PIN_HIZ;
                2'h1: mode = flfc_pkg::FLFC_MANUAL;
                2'h2: mode = flfc_pkg::FLFC_PIN_LOW;
                2'h3: mode = flfc_pkg::FLFC_PIN_HIGH;
            endcase
        end
    end

    // automatic fastlock timer; leaving auto mode cancels a running period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fl_state_q <= flfc_pkg::FLFC_FL_IDLE;
            fl_cnt_q   <= 15'h0000;
        end else if (mode != flfc_pkg::FLFC_AUTO) begin
            fl_state_q <= flfc_pkg::FLFC_FL_IDLE;
            fl_cnt_q   <= 15'h0000;
        end else if (freq_wr) begin
            fl_state_q <= flfc_pkg::FLFC_FL_RUN;
            fl_cnt_q   <= {main_fastlock_timeout_q, 1'b0};
        end else if ((fl_state_q == flfc_pkg::FLFC_FL_RUN) && pd_ev) begin
            if (fl_cnt_q == 15'h0001) begin
                fl_state_q <= flfc_pkg::FLFC_FL_IDLE;
                fl_cnt_q   <= 15'h0000;
            end else begin
                fl_cnt_q <= fl_cnt_q - 15'h0001;
            end
        end
    end

    assign fl_on = (mode == flfc_pkg::FLFC_MANUAL)
                   || (fl_state_q == flfc_pkg::FLFC_FL_RUN);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fastlock_active <= 1'b0;
            pump_mult       <= 5'h01;
        end else begin
            fastlock_active <= fl_on;
            pump_mult       <= fl_on ? ({1'b0, fastlock_pump_current_q}
                                        + 5'h01) : 5'h01;
        end
    end

    // pin enable is low while driving
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fl_pin_out  <= 1'b0;
            fl_pin_oe_n <= 1'b1;
        end else begin
            unique case (mode)
                flfc_pkg::FLFC_PIN_HIZ: begin
                    fl_pin_out  <= 1'b0;
                    fl_pin_oe_n <= 1'b1;
                end
                flfc_pkg::FLFC_MANUAL,
                flfc_pkg::FLFC_PIN_LOW: begin
                    fl_pin_out  <= 1'b0;
                    fl_pin_oe_n <= 1'b0;
                end
                flfc_pkg::FLFC_PIN_HIGH: begin
                    fl_pin_out  <= 1'b1;
                    fl_pin_oe_n <= 1'b0;
                end
                flfc_pkg::FLFC_AUTO: begin
                    fl_pin_out  <= fl_on;
                    fl_pin_oe_n <= 1'b0;
                end
            endcase
        end
    end

    // upper bits masked so stale values cannot leak into 12-bit mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            main_fraction_denominator <= `FLFC_DEN_RST;
            wide_frac                 <= 1'b0;
        end else begin
            wide_frac <= wide_q;
            if (wide_q) begin
                main_fraction_denominator <= den_raw_q;
            end else begin
                main_fraction_denominator <= {10'h000,
                                              den_raw_q[11:0]};
            end
        end
    end

    // counter reset also floats the pump; float alone leaves counters alone
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            main_counter_reset <= 1'b0;
            aux_counter_reset  <= 1'b0;
            main_pump_tri      <= 1'b0;
            aux_pump_tri       <= 1'b0;
        end else begin
            main_counter_reset <= main_reset_q;
            aux_counter_reset  <= aux_reset_q;
            main_pump_tri      <= main_reset_q || main_pump_float_q;
            aux_pump_tri       <= aux_reset_q || aux_pump_float_q;
        end
    end

    always_comb begin
        unique case (cycle_slip_reduction_q)
            2'h0: slip_ratio_m1 = 4'h0;
            2'h1: slip_ratio_m1 = `FLFC_SLIP1_M1;
            2'h2: slip_ratio_m1 = `FLFC_SLIP2_M1;
            2'h3: slip_ratio_m1 = `FLFC_SLIP3_M1;
        endcase
    end

    assign ld_ratio_m1 = lock_detect_prescale_q ? `FLFC_LD_DIV_M1
                                                : 4'h0;

    flfc_evdiv u_slip_div (
        .clk      (clk),
        .nrst     (nrst),
        .ev       (pd_ev),
        .ratio_m1 (slip_ratio_m1),
        .pulse_q  (slip_sample_en)
    );

    flfc_evdiv u_ld_div (
        .clk      (clk),
        .nrst     (nrst),
        .ev       (pd_ev),
        .ratio_m1 (ld_ratio_m1),
        .pulse_q  (ld_sample_en)
    );

    // readback; the word port itself is write only
    always_comb begin
        rd_val = 24'h000000;
        unique case (addr)
            `FLFC_ADDR_DEN: begin
                rd_val[21:0]               = den_raw_q;
                rd_val[`FLFC_DEN_WIDE_BIT] = wide_q;
            end
            `FLFC_ADDR_STAT: begin
                rd_val[`FLFC_STAT_ACT_BIT] = fl_on;
                rd_val[`FLFC_STAT_PIN_BIT] = pin_in_lvl;
                rd_val[`FLFC_STAT_ERR_BIT] = bad_word_q;
                rd_val[`FLFC_STAT_CNT_LSB +: 15] = fl_cnt_q;
            end
            default: rd_val = 24'h000000;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 24'h000000;
        end else begin
            rdata <= rd ? rd_val : 24'h000000;
        end
    end
endmodule

/* File: hw/flfc_evdiv.sv */
// event divider: one output pulse per ratio_m1+1 input events
`timescale 1ns/1ps
module flfc_evdiv (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       ev,
    input  wire logic [3:0] ratio_m1,
    output logic            pulse_q
);
    logic [3:0] cnt_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q   <= 4'h0;
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= 1'b0;
            if (ev) begin
                // >= so a smaller ratio written mid-count cannot overrun
                if (cnt_q >= ratio_m1) begin
                    cnt_q   <= 4'h0;
                    pulse_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule

/* File: hw/flfc_map.svh */
// register map, field positions and reset values of the fastlock control
// Function
// - width bit 0: use 12-bit denominator, upper ten bits ignored
// - width bit 1: upper and lower fields form one 22-bit denominator
// - timeout 0, 2, 3: fastlock off; pin 0 hi-z, 2 low, 3 high
// - timeout 1: manual fastlock, pin driven low, fastlock forced on
// - timeout 4..16383: automatic fastlock, pin shows fastlock state
// - automatic fastlock lasts twice the timeout in comparison events
// - during fastlock pump multiple equals current code plus one
// - slip code 0,1,2,3 samples every 1st, 2nd, 4th, 16th event
// - prescale bit divides comparison events by 4 for lock detect
// - aux reset bit holds aux counters and floats aux pump
// - main reset bit holds main counters and floats main pump
// - pump float bit floats that pump, counters keep running
`ifndef FLFC_MAP_SVH
`define FLFC_MAP_SVH

`define FLFC_ADDR_WORD   4'h0
`define FLFC_ADDR_DEN    4'h1
`define FLFC_ADDR_STAT   4'h2

`define FLFC_SEL_FREQ    4'h0
`define FLFC_SEL_FAST    4'hd
`define FLFC_SEL_RST     4'hf

`define FLFC_SLIP_MSB    23
`define FLFC_SLIP_LSB    22
`define FLFC_CPF_MSB     21
`define FLFC_CPF_LSB     18
`define FLFC_TOC_MSB     17
`define FLFC_TOC_LSB     4
`define FLFC_LDPRE_BIT   13
`define FLFC_AUXRST_BIT  7
`define FLFC_MAINRST_BIT 6
`define FLFC_AUXFLT_BIT  5
`define FLFC_MAINFLT_BIT 4
`define FLFC_RST_FIXMASK 24'hffdf00
`define FLFC_RST_FIXVAL  24'h000800

`define FLFC_DEN_WIDE_BIT 22
`define FLFC_STAT_ACT_BIT 0
`define FLFC_STAT_PIN_BIT 1
`define FLFC_STAT_ERR_BIT 2
`define FLFC_STAT_CNT_LSB 8

`define FLFC_TOC_AUTO_MIN 14'h0004
`define FLFC_LD_DIV_M1    4'h3
`define FLFC_SLIP1_M1     4'h1
`define FLFC_SLIP2_M1     4'h3
`define FLFC_SLIP3_M1     4'hf

`define FLFC_TOC_RST      14'h0000
`define FLFC_CPF_RST      4'h0
`define FLFC_SLIP_RST     2'h0
`define FLFC_DEN_RST      22'h000000

`endif

/* File: hw/flfc_pkg.sv */
// types shared by the fastlock control block
package flfc_pkg;
    typedef enum logic [2:0] {
        FLFC_PIN_HIZ  = 3'b000,
        FLFC_MANUAL   = 3'b001,
        FLFC_PIN_LOW  = 3'b010,
        FLFC_PIN_HIGH = 3'b011,
        FLFC_AUTO     = 3'b100
    } flfc_mode_e;

    typedef enum logic {
        FLFC_FL_IDLE = 1'b0,
        FLFC_FL_RUN  = 1'b1
    } flfc_fl_state_e;
endpackage

/* File: hw/flfc_sync3.sv */
// three-stage input synchroniser, change taken once stages two and three agree
`timescale 1ns/1ps
module flfc_sync3 (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a one-cycle disagreement is treated as metastable noise
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dout <= 1'b0;
        end else if (s2_q == s3_q) begin
            dout <= s3_q;
        end
    end
endmodule
